//--- logic/stc_pkg.sv
// Constants and types for the serial transmit control block
`default_nettype none
package stc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned REG_AW    = 6;
  localparam logic [5:0]  OFF_CTRL  = 6'h00;
  localparam logic [5:0]  OFF_RXEN  = 6'h04;
  localparam logic [5:0]  OFF_DATA  = 6'h08;
  localparam logic [5:0]  OFF_BAUD  = 6'h0C;
  localparam logic [5:0]  OFF_IRQS  = 6'h10;
  localparam logic [5:0]  OFF_IRQM  = 6'h14;

  localparam logic [7:0]  CTRL_RESET = 8'h02;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ************************************************************
  // Framing and timing
  // ************************************************************
  localparam logic [3:0]  DATA_LAST  = 4'h7;
  localparam logic [3:0]  BREAK_LAST = 4'hB;
  localparam logic [1:0]  LOW_PRESCALE_LAST = 2'h3;

  typedef struct packed {
    logic clockSourceSelect;
    logic nineBitTxSelect;
    logic transmitEnable;
    logic syncMode;
    logic breakSendRequest;
    logic highRateSelect;
    logic shifterEmptyFlag;
    logic ninthTxBit;
  } stc_ctl_t;

  typedef struct packed {
    logic continuousReceiveEnable;
    logic singleReceiveEnable;
  } stc_rxen_t;

  typedef struct packed {
    logic breakDone;
    logic frameDone;
  } stc_irq_t;

  typedef enum logic [2:0] {PH_IDLE, PH_START, PH_DATA, PH_NINTH, PH_BREAK, PH_STOP} stc_phase_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } stc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stc_axi_rsp_t;

endpackage
`default_nettype wire

//--- logic/stc_baud_tick.sv
// Bit-rate tick generator with low-speed prescaler
`timescale 1ns/1ps
`default_nettype none
module stc_baud_tick
  import stc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] divisor,
  input  wire logic        highRate,
  output var  logic        tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [1:0]  pre;
    logic        tick;
  } stc_baud_t;

  stc_baud_t s_ff;
  stc_baud_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (!run) begin
      nxt_s.cnt = '0;
      nxt_s.pre = '0;
    end else if (s_ff.cnt == divisor) begin
      nxt_s.cnt = '0;
      if (highRate || s_ff.pre == LOW_PRESCALE_LAST) begin
        nxt_s.pre  = '0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.pre = s_ff.pre + 2'h1;
      end
    end else begin
      nxt_s.cnt = s_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_low_rate_gap: assert property (tick && !highRate && run |=> !tick [*3])
    else $error("Low speed tick came too soon");

endmodule // stc_baud_tick
`default_nettype wire

//--- logic/stc_serial_transmit_control.sv
// Transmit control, shifter and AXI4-Lite register slave
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stc_serial_transmit_control
  import stc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire stc_axi_req_t axiReq,
  output var  stc_axi_rsp_t axiRsp,
  input  wire logic         sckIn,
  output var  logic         sckOut,
  output var  logic         sckOe,
  output var  logic         txOut,
  output var  logic         txOe,
  output var  logic         irq
);

  typedef struct packed {
    stc_axi_rsp_t rsp;
    logic [5:0]   awAddr;
    logic [31:0]  wData;
    logic [3:0]   wStrb;
    stc_ctl_t     ctl;
    stc_rxen_t    rxEn;
    logic [15:0]  baudDiv;
    stc_irq_t     irqStat;
    stc_irq_t     irqMask;
    logic         irq;
    stc_phase_t   phase;
    logic [3:0]   bitCnt;
    logic [8:0]   shift;
    logic         frame9;
    logic         isBreak;
    logic         sclk;
    logic [2:0]   sckSync;
    logic         sckStable;
    logic         txOut;
    logic         txOe;
    logic         sckOe;
  } stc_core_t;

  stc_core_t s_ff;
  stc_core_t nxt_s;

  logic       baudTick;
  logic       baudRun;
  logic       doWrite;
  logic       laneLo;
  logic       laneHi;
  logic       wrCtl;
  logic       wrData;
  logic       txAllowed;
  logic       sckFall;
  logic       step;
  logic       finish;
  logic [31:0] rdVal;
  logic       rdOk;
  stc_irq_t   events;
  stc_ctl_t   wrCtlVal;

  // ************************************************************
  // Bit timing
  // ************************************************************
  assign baudRun = (s_ff.phase != PH_IDLE) && !(s_ff.ctl.syncMode && !s_ff.ctl.clockSourceSelect);

  stc_baud_tick u_baud (
    .clk      (clk),
    .rst      (rst),
    .run      (baudRun),
    .divisor  (s_ff.baudDiv),
    .highRate (s_ff.ctl.highRateSelect || s_ff.ctl.syncMode),
    .tick     (baudTick)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_s = s_ff;
    events = '0;
    rdVal = '0;
    rdOk = 1'b1;
    finish = 1'b0;

    // Write address and data taken in either order
    if (axiReq.awvalid && s_ff.rsp.awready) begin
      nxt_s.rsp.awready = 1'b0;
      nxt_s.awAddr = axiReq.awaddr[REG_AW-1:0];
    end
    if (axiReq.wvalid && s_ff.rsp.wready) begin
      nxt_s.rsp.wready = 1'b0;
      nxt_s.wData = axiReq.wdata;
      nxt_s.wStrb = axiReq.wstrb;
    end
    doWrite = !s_ff.rsp.awready && !s_ff.rsp.wready && !s_ff.rsp.bvalid;
    laneLo = doWrite && s_ff.wStrb[0];
    laneHi = doWrite && s_ff.wStrb[1];
    wrCtl = laneLo && (s_ff.awAddr == OFF_CTRL);
    wrData = laneLo && (s_ff.awAddr == OFF_DATA);
    wrCtlVal = stc_ctl_t'(s_ff.wData[7:0]);
    if (doWrite) begin
      nxt_s.rsp.bvalid = 1'b1;
      case (s_ff.awAddr)
        OFF_CTRL, OFF_RXEN, OFF_DATA, OFF_BAUD, OFF_IRQS, OFF_IRQM: nxt_s.rsp.bresp = RESP_OKAY;
        default: nxt_s.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (s_ff.rsp.bvalid && axiReq.bready) begin
      nxt_s.rsp.bvalid = 1'b0;
      nxt_s.rsp.awready = 1'b1;
      nxt_s.rsp.wready = 1'b1;
    end

    // Register read
    case (axiReq.araddr[REG_AW-1:0])
      OFF_CTRL: rdVal[7:0] = s_ff.ctl;
      OFF_RXEN: rdVal[1:0] = s_ff.rxEn;
      OFF_DATA: rdVal = '0;
      OFF_BAUD: rdVal[15:0] = s_ff.baudDiv;
      OFF_IRQS: rdVal[1:0] = s_ff.irqStat;
      OFF_IRQM: rdVal[1:0] = s_ff.irqMask;
      default: rdOk = 1'b0;
    endcase
    if (axiReq.arvalid && s_ff.rsp.arready) begin
      nxt_s.rsp.arready = 1'b0;
      nxt_s.rsp.rvalid = 1'b1;
      nxt_s.rsp.rdata = rdVal;
      nxt_s.rsp.rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_ff.rsp.rvalid && axiReq.rready) begin
      nxt_s.rsp.rvalid = 1'b0;
      nxt_s.rsp.arready = 1'b1;
    end

    // Control writes
    if (wrCtl) begin
      nxt_s.ctl.clockSourceSelect = wrCtlVal.clockSourceSelect;
      nxt_s.ctl.nineBitTxSelect = wrCtlVal.nineBitTxSelect;
      nxt_s.ctl.transmitEnable = wrCtlVal.transmitEnable;
      nxt_s.ctl.syncMode = wrCtlVal.syncMode;
      nxt_s.ctl.highRateSelect = wrCtlVal.highRateSelect;
      nxt_s.ctl.ninthTxBit = wrCtlVal.ninthTxBit;
    end
    if (laneLo && s_ff.awAddr == OFF_RXEN) begin
      nxt_s.rxEn = stc_rxen_t'(s_ff.wData[1:0]);
    end
    if (laneLo && s_ff.awAddr == OFF_BAUD) begin
      nxt_s.baudDiv[7:0] = s_ff.wData[7:0];
    end
    if (laneHi && s_ff.awAddr == OFF_BAUD) begin
      nxt_s.baudDiv[15:8] = s_ff.wData[15:8];
    end
    if (laneLo && s_ff.awAddr == OFF_IRQM) begin
      nxt_s.irqMask = stc_irq_t'(s_ff.wData[1:0]);
    end

    // External clock: three stages, change taken once stages two and three agree
    nxt_s.sckSync = {s_ff.sckSync[1:0], sckIn};
    if (s_ff.sckSync[1] == s_ff.sckSync[2]) begin
      nxt_s.sckStable = s_ff.sckSync[2];
    end
    sckFall = s_ff.sckStable && (s_ff.sckSync[1] == s_ff.sckSync[2]) && !s_ff.sckSync[2];

    // ************************************************************
    // Transmit engine
    // ************************************************************
    txAllowed = s_ff.ctl.transmitEnable
      && !(s_ff.ctl.syncMode && (s_ff.rxEn.singleReceiveEnable || s_ff.rxEn.continuousReceiveEnable));

    if (s_ff.ctl.syncMode && s_ff.ctl.clockSourceSelect && s_ff.phase != PH_IDLE && baudTick) begin
      nxt_s.sclk = !s_ff.sclk;
    end
    if (!s_ff.ctl.syncMode) begin
      step = baudTick;
    end else if (s_ff.ctl.clockSourceSelect) begin
      step = baudTick && s_ff.sclk;
    end else begin
      step = sckFall;
    end

    case (s_ff.phase)
      PH_IDLE: begin
        nxt_s.txOut = 1'b1;
        nxt_s.sclk = 1'b0;
        if (wrData && txAllowed) begin
          nxt_s.bitCnt = '0;
          nxt_s.shift = {s_ff.ctl.ninthTxBit, s_ff.wData[7:0]};
          nxt_s.frame9 = s_ff.ctl.nineBitTxSelect;
          nxt_s.isBreak = !s_ff.ctl.syncMode && s_ff.ctl.breakSendRequest;
          if (s_ff.ctl.syncMode) begin
            nxt_s.phase = PH_DATA;
            nxt_s.txOut = s_ff.wData[0];
          end else begin
            nxt_s.phase = PH_START;
            nxt_s.txOut = 1'b0;
          end
        end
      end
      PH_START: begin
        if (step) begin
          nxt_s.bitCnt = '0;
          nxt_s.phase = s_ff.isBreak ? PH_BREAK : PH_DATA;
          nxt_s.txOut = s_ff.isBreak ? 1'b0 : s_ff.shift[0];
        end
      end
      PH_DATA: begin
        if (step) begin
          nxt_s.shift = {1'b0, s_ff.shift[8:1]};
          nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
          nxt_s.txOut = s_ff.shift[1];
          if (s_ff.bitCnt == DATA_LAST) begin
            if (s_ff.frame9) begin
              nxt_s.phase = PH_NINTH;
            end else begin
              finish = 1'b1;
            end
          end
        end
      end
      PH_NINTH: begin
        if (step) begin
          finish = 1'b1;
        end
      end
      PH_BREAK: begin
        if (step) begin
          nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
          if (s_ff.bitCnt == BREAK_LAST) begin
            nxt_s.phase = PH_STOP;
            nxt_s.txOut = 1'b1;
          end
        end
      end
      PH_STOP: begin
        if (step) begin
          nxt_s.phase = PH_IDLE;
          if (s_ff.isBreak) begin
            events.breakDone = 1'b1;
            nxt_s.ctl.breakSendRequest = 1'b0;
          end else begin
            events.frameDone = 1'b1;
          end
        end
      end
      default: begin
        nxt_s.phase = PH_IDLE;
      end
    endcase

    if (finish) begin
      nxt_s.txOut = 1'b1;
      if (s_ff.ctl.syncMode) begin
        nxt_s.phase = PH_IDLE;
        events.frameDone = 1'b1;
      end else begin
        nxt_s.phase = PH_STOP;
      end
    end

    if (!txAllowed) begin
      nxt_s.phase = PH_IDLE;
      nxt_s.txOut = 1'b1;
      nxt_s.sclk = 1'b0;
    end

    // Leaving sync master mid-frame must not park the clock high
    if (!(s_ff.ctl.syncMode && s_ff.ctl.clockSourceSelect)) begin
      nxt_s.sclk = 1'b0;
    end

    // Software setting the break request wins over the hardware clear
    if (wrCtl && wrCtlVal.breakSendRequest) begin
      nxt_s.ctl.breakSendRequest = 1'b1;
    end

    nxt_s.ctl.shifterEmptyFlag = (nxt_s.phase == PH_IDLE);
    nxt_s.txOe = txAllowed;
    nxt_s.sckOe = s_ff.ctl.syncMode && s_ff.ctl.clockSourceSelect && txAllowed;

    // Sticky status: new events win over write-one-to-clear
    if (laneLo && s_ff.awAddr == OFF_IRQS) begin
      nxt_s.irqStat = s_ff.irqStat & ~stc_irq_t'(s_ff.wData[1:0]);
    end
    nxt_s.irqStat = nxt_s.irqStat | events;
    nxt_s.irq = |(nxt_s.irqStat & nxt_s.irqMask);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.rsp.awready <= 1'b1;
      s_ff.rsp.wready <= 1'b1;
      s_ff.rsp.arready <= 1'b1;
      s_ff.ctl <= stc_ctl_t'(CTRL_RESET);
      s_ff.baudDiv <= BAUD_RESET;
      s_ff.phase <= PH_IDLE;
      s_ff.txOut <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign axiRsp = s_ff.rsp;
  assign sckOut = s_ff.sclk;
  assign sckOe = s_ff.sckOe;
  assign txOut = s_ff.txOut;
  assign txOe = s_ff.txOe;
  assign irq = s_ff.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_master_clock_oe: assert property (
    s_ff.ctl.syncMode && s_ff.ctl.clockSourceSelect && txAllowed |=> sckOe)
    else $error("Master clock not driven");
  chk_slave_clock_off: assert property (
    !(s_ff.ctl.syncMode && s_ff.ctl.clockSourceSelect) |=> !sckOe && !sckOut)
    else $error("Clock driven outside sync master");
  chk_eight_bit_end: assert property (
    s_ff.phase == PH_DATA && step && s_ff.bitCnt == DATA_LAST && !s_ff.frame9 |=> s_ff.phase != PH_NINTH)
    else $error("Ninth bit sent in eight-bit frame");
  chk_disable_stops: assert property (!s_ff.ctl.transmitEnable |=> s_ff.phase == PH_IDLE && txOut)
    else $error("Transmit ran while disabled");
  chk_receive_wins: assert property (
    s_ff.ctl.syncMode && (s_ff.rxEn.singleReceiveEnable || s_ff.rxEn.continuousReceiveEnable)
    |=> s_ff.phase == PH_IDLE && !txOe)
    else $error("Receive enable did not override transmit");
  chk_async_start: assert property (
    s_ff.phase == PH_IDLE && wrData && txAllowed && !s_ff.ctl.syncMode |=> !txOut && s_ff.phase == PH_START)
    else $error("Missing start bit");
  chk_break_clear: assert property (
    s_ff.phase == PH_STOP && step && s_ff.isBreak && !wrCtl && txAllowed
    |=> !s_ff.ctl.breakSendRequest && s_ff.irqStat.breakDone)
    else $error("Break request not cleared");
  chk_break_low: assert property (s_ff.phase == PH_BREAK |-> !txOut)
    else $error("Break bit not low");
  chk_empty_flag: assert property ($fell(s_ff.ctl.shifterEmptyFlag) |-> $past(wrData))
    else $error("Empty flag fell without a load");
  chk_ninth_out: assert property (
    s_ff.phase == PH_NINTH |-> s_ff.frame9 && txOut == s_ff.shift[0])
    else $error("Ninth bit wrong");
  chk_ninth_store: assert property (wrCtl |=> s_ff.ctl.ninthTxBit == $past(s_ff.wData[0]))
    else $error("Ninth bit not stored");
  chk_irq_level: assert property (##1 irq == |(s_ff.irqStat & s_ff.irqMask))
    else $error("Interrupt level wrong");

  cov_break_sent: cover property (events.breakDone);
  cov_nine_frame: cover property (s_ff.phase == PH_NINTH && step);
  cov_sync_master: cover property (s_ff.ctl.syncMode && s_ff.ctl.clockSourceSelect && events.frameDone);
  cov_irq_raised: cover property ($rose(irq));

endmodule // stc_serial_transmit_control
`default_nettype wire

//--- testbench/stc_remote_node.sv
// Remote serial node: line sampler and slave clock source
`timescale 1ns/1ps
`default_nettype none
module stc_remote_node (
  input  wire logic        clk,
  input  wire logic        txOut,
  input  wire logic        txOe,
  input  wire logic        slaveClk,
  input  var  int          bitClks,
  input  var  int          nBits,
  output var  logic        sckIn,
  output var  logic [15:0] word,
  output var  int          rxCount
);
  logic [15:0] sh;
  initial begin
    sckIn = 1'b0;
    word = 16'h0000;
    rxCount = 0;
  end
  // ************************************************************
  // Slave clock, still and low unless asked
  // ************************************************************
  always begin
    @(posedge clk);
    if (slaveClk) begin
      repeat (7) @(posedge clk);
      sckIn <= ~sckIn;
    end else begin
      sckIn <= 1'b0;
    end
  end
  // ************************************************************
  // Mid-bit sampling from the start edge, first bit lowest
  // ************************************************************
  always begin
    @(negedge txOut);
    if (txOe) begin
      sh = 16'h0000;
      repeat (bitClks / 2) @(posedge clk);
      for (int k = 0; k < nBits; k++) begin
        sh[k] = txOut;
        if (k < nBits - 1) repeat (bitClks) @(posedge clk);
      end
      word = sh;
      rxCount++;
    end
  end
endmodule // stc_remote_node
`default_nettype wire

//--- testbench/stc_serial_transmit_control_tb.sv
// Self-checking bench for the serial transmit control block
`timescale 1ns/1ps
`default_nettype none
module stc_serial_transmit_control_tb;
  import stc_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } stc_row_t;
  localparam stc_row_t ROWS [12] = '{
    '{1'b0, OFF_CTRL, 32'h0000_0002, RESP_OKAY},
    '{1'b0, OFF_RXEN, 32'h0000_0000, RESP_OKAY},
    '{1'b0, OFF_BAUD, 32'h0000_0000, RESP_OKAY},
    '{1'b0, OFF_IRQS, 32'h0000_0000, RESP_OKAY},
    '{1'b0, OFF_DATA, 32'h0000_0000, RESP_OKAY},
    '{1'b1, 6'h18, 32'h0000_00FF, RESP_SLVERR},
    '{1'b0, 6'h18, 32'h0000_0000, RESP_SLVERR},
    '{1'b1, OFF_CTRL, 32'h0000_0041, RESP_OKAY},
    '{1'b0, OFF_CTRL, 32'h0000_0043, RESP_OKAY},
    '{1'b1, OFF_BAUD, 32'h0000_0003, RESP_OKAY},
    '{1'b0, OFF_BAUD, 32'h0000_0003, RESP_OKAY},
    '{1'b1, OFF_IRQM, 32'h0000_0001, RESP_OKAY}
  };
  logic         clk;
  logic         rst;
  stc_axi_req_t req;
  stc_axi_rsp_t rsp;
  logic         sckIn;
  logic         sckOe;
  logic         txOut;
  logic         txOe;
  logic         irq;
  logic         slaveClk;
  logic [15:0]  word;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           bitClks;
  int           nBits;
  int           rxCount;
  int           base;
  int           n_mismatch;
  int           total_checks;

  stc_serial_transmit_control uut (.clk(clk), .rst(rst), .axiReq(req), .axiRsp(rsp), .sckIn(sckIn),
    .sckOut(), .sckOe(sckOe), .txOut(txOut), .txOe(txOe), .irq(irq));
  stc_remote_node node (.clk(clk), .txOut(txOut), .txOe(txOe), .slaveClk(slaveClk), .bitClks(bitClks),
    .nBits(nBits), .sckIn(sckIn), .word(word), .rxCount(rxCount));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ************************************************************
  // Compare, bus and frame tasks
  // ************************************************************
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    req.awaddr <= {26'h000_0000, a};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rs = rsp.bresp;
  endtask
  task automatic axr(input logic [5:0] a);
    req.araddr <= {26'h000_0000, a};
    req.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rd = rsp.rdata;
    rs = rsp.rresp;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    axr(a);
    cmp_word(rd, e);
  endtask
  task automatic idle();
    for (int i = 0; i < 200; i++) begin
      axr(OFF_CTRL);
      if (rd[1]) break;
    end
  endtask
  // Second data write lands while busy and must be dropped
  task automatic send(input logic [31:0] c, input logic [31:0] d, input int nb, input int bc,
                      input logic [15:0] exp);
    axw(OFF_CTRL, c);
    nBits = nb;
    bitClks = bc;
    base = rxCount;
    axw(OFF_DATA, d);
    axw(OFF_DATA, ~d);
    axr(OFF_CTRL);
    cmp_bit(rd[1], 1'b0);
    for (int i = 0; i < 4000 && rxCount == base; i++) @(posedge clk);
    cmp_word({16'h0000, word}, {16'h0000, exp});
    idle();
    repeat (bc * 16) @(posedge clk);
    cmp_word(rxCount, base + 1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    req = '0;
    slaveClk = 1'b0;
    bitClks = 4;
    nBits = 10;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp_bit(txOut, 1'b1);
    cmp_bit(txOe, 1'b0);
    cmp_bit(sckOe, 1'b0);
    cmp_bit(irq, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) axw(ROWS[i].addr, ROWS[i].data);
      else rdchk(ROWS[i].addr, ROWS[i].data);
      cmp_word({30'h0000_0000, rs}, {30'h0000_0000, ROWS[i].resp});
    end
    send(32'h0000_0024, 32'h0000_00A5, 10, 4, 16'h034A);
    cmp_bit(irq, 1'b1);
    axw(OFF_IRQS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b0);
    axw(OFF_IRQM, 32'h0000_0002);
    send(32'h0000_0065, 32'h0000_003C, 11, 4, 16'h0678);
    cmp_bit(irq, 1'b0);
    send(32'h0000_002C, 32'h0000_0055, 14, 4, 16'h2000);
    rdchk(OFF_CTRL, 32'h0000_0026);
    cmp_bit(irq, 1'b1);
    axw(OFF_IRQS, 32'h0000_0003);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b0);
    send(32'h0000_0020, 32'h0000_0081, 10, 16, 16'h0302);
    axw(OFF_CTRL, 32'h0000_0000);
    base = rxCount;
    axw(OFF_DATA, 32'h0000_0012);
    repeat (100) @(posedge clk);
    cmp_bit(txOe, 1'b0);
    cmp_bit(txOut, 1'b1);
    cmp_word(rxCount, base);
    rdchk(OFF_CTRL, 32'h0000_0002);
    axw(OFF_CTRL, 32'h0000_00A0);
    repeat (3) @(posedge clk);
    cmp_bit(sckOe, 1'b0);
    axw(OFF_CTRL, 32'h0000_00B0);
    repeat (3) @(posedge clk);
    cmp_bit(sckOe, 1'b1);
    cmp_bit(txOe, 1'b1);
    axw(OFF_DATA, 32'h0000_005A);
    idle();
    rdchk(OFF_CTRL, 32'h0000_00B2);
    for (int e = 1; e < 3; e++) begin
      axw(OFF_RXEN, e);
      repeat (3) @(posedge clk);
      cmp_bit(txOe, 1'b0);
    end
    axw(OFF_RXEN, 32'h0000_0000);
    axw(OFF_CTRL, 32'h0000_0030);
    slaveClk <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_bit(sckOe, 1'b0);
    axw(OFF_DATA, 32'h0000_005A);
    rdchk(OFF_CTRL, 32'h0000_0030);
    idle();
    rdchk(OFF_CTRL, 32'h0000_0032);
    slaveClk <= 1'b0;
    wrap_up();
  end
endmodule // stc_serial_transmit_control_tb
`default_nettype wire
